// File: hdl/svc_pkg.sv
/*
  Shared types and constants of the servo command and interlock block.
  Assumes a 250 MHz control clock; all timing counts derive from it.
*/
package svc_pkg;
  typedef enum logic [1:0] {
    MODE_POS = 2'b00,
    MODE_SPD = 2'b01,
    MODE_TRQ = 2'b10,
    MODE_PTB = 2'b11
  } ctrl_mode_t;
  typedef enum logic [1:0] {
    FORM_FR = 2'b00,
    FORM_PS = 2'b01,
    FORM_AB = 2'b10
  } pulse_form_t;
  typedef enum logic [1:0] {
    DSP_LAMP  = 2'b00,
    DSP_LABEL = 2'b01,
    DSP_DATA  = 2'b10
  } disp_state_t;
  localparam int CLK_HZ       = 250_000_000;
  localparam int CLK_NS       = 4;
  localparam int LAMP_TIME_US = 1000;
  localparam int LAMP_CYC     = LAMP_TIME_US * (CLK_HZ / 1_000_000);
  localparam int LABEL_TIME_S = 2;
  localparam int LABEL_CYC    = LABEL_TIME_S * CLK_HZ;
  localparam int FILT1_NS     = 200;
  localparam int FILT2_NS     = 500;
  localparam int FILT1_CYC    = (FILT1_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT2_CYC    = (FILT2_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_W       = 7;
  localparam logic [8:0] PPR_NATIVE  = 9'h000;
  localparam logic [8:0] PPR_MIN     = 9'h064;
  localparam logic [8:0] PPR_MAX     = 9'h1f4;
  localparam logic [8:0] PPR_DEFAULT = 9'h064;
  localparam logic [31:0] PPR_UNIT   = 32'h0000_0064;
  localparam int ENC_RES_DEF  = 131072;
  localparam int GEAR_W       = 16;
  localparam int POS_W        = 32;
  localparam logic [7:0] WARN_NONE   = 8'h00;
  localparam logic [7:0] WARN_ESTOP  = 8'h61;
  localparam int PFS_W        = 6;
  localparam int PFS_FORM_LSB = 0;
  localparam int PFS_NEG_BIT  = 2;
  localparam int PFS_FILT_LSB = 4;
  localparam int PIN_W   = 11;
  localparam int PIN_SON = 0;
  localparam int PIN_EM  = 1;
  localparam int PIN_FL  = 2;
  localparam int PIN_RL  = 3;
  localparam int PIN_FS  = 4;
  localparam int PIN_RS  = 5;
  localparam int PIN_FT  = 6;
  localparam int PIN_RT  = 7;
  localparam int PIN_BTN = 8;
  localparam int PIN_A   = 9;
  localparam int PIN_B   = 10;
  localparam int DO_W    = 2;
  localparam int DO_RDY  = 0;
  localparam int DO_ALM  = 1;
endpackage

// File: hdl/pin_sync.sv
/*
  Three-stage pin synchroniser; a change is taken once stages two and three agree.
  Assumes asynchronous pins and one clock.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;
  sync_t st_reg;
  sync_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = i_pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_q = st_reg.q;
endmodule

// File: hdl/pulse_decoder.sv
/*
  Command pulse decoder: noise filter, polarity, and the three input forms.
  Assumes synchronised A and B inputs on the control clock.
*/
`timescale 1ns/10ps
module pulse_decoder (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // Pulse inputs
  input  wire logic       i_a,
  input  wire logic       i_b,
  // Settings
  input  wire logic [1:0] i_form,
  input  wire logic       i_neg,
  input  wire logic [1:0] i_filt,
  // Decoded count
  output logic            o_step,
  output logic            o_fwd
);
  typedef struct packed {
    logic [1:0]                          fv;
    logic [1:0][svc_pkg::FILT_W-1:0]     cnt;
    logic                                step;
    logic                                fwd;
  } dec_t;
  dec_t st_reg;
  dec_t st_next;
  logic [svc_pkg::FILT_W-1:0] thr;
  logic [1:0]                 raw;
  logic [1:0]                 nv;

  always_comb begin
    thr = (i_filt == 2'h1) ? svc_pkg::FILT_W'(svc_pkg::FILT1_CYC) :
          (i_filt == 2'h2) ? svc_pkg::FILT_W'(svc_pkg::FILT2_CYC) : 7'h01;
    raw = {i_b, i_a} ^ {2{i_neg}};
    st_next      = st_reg;
    st_next.step = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (raw[i] == st_reg.fv[i]) begin
        st_next.cnt[i] = '0;
      end else if (st_reg.cnt[i] + 7'h01 >= thr) begin
        st_next.fv[i]  = raw[i];
        st_next.cnt[i] = '0;
      end else begin
        st_next.cnt[i] = st_reg.cnt[i] + 7'h01;
      end
    end
    nv = st_next.fv;
    unique case (i_form)
      svc_pkg::FORM_PS: begin
        st_next.step = nv[0] & ~st_reg.fv[0];
        st_next.fwd  = ~nv[1];
      end
      svc_pkg::FORM_AB: begin
        st_next.step = (nv[0] ^ st_reg.fv[0]) ^ (nv[1] ^ st_reg.fv[1]);
        st_next.fwd  = ~(st_reg.fv[0] ^ nv[1]);
      end
      default: begin
        st_next.step = (nv[0] & ~st_reg.fv[0]) ^ (nv[1] & ~st_reg.fv[1]);
        st_next.fwd  = nv[0] & ~st_reg.fv[0];
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_step = st_reg.step;
  assign o_fwd  = st_reg.fwd;

  a_quad_edge: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_form == svc_pkg::FORM_AB && $countones(st_next.fv ^ st_reg.fv) == 1) |=> o_step)
    else $error("Quadrature edge produced no count.");
endmodule

// File: hdl/servo_command_interlock.sv
/*
  Command and interlock logic of a servo amplifier: pulse scaling, run, coast
  and brake decisions, ready and forced-stop indication, start-up display.
  Assumes the pins arrive asynchronously, and that alarm and feedback come
  from logic on the same clock.
*/
// Summary of operation
// - At power-up the lamp check pattern shows briefly and raises no alarm.
// - Position mode shows the feedback label, then data after 2 s or a button.
// - Pulses per revolution: 0 uses the gear ratio, 100 to 500 mean times 100.
// - Pulses per revolution setting defaults to 100, ten thousand per turn.
// - Command counts are scaled by gear numerator over denominator when pulses per revolution is 0.
// - Three pulse input forms, each with positive or negative logic.
// - Quadrature form counts every edge of both phases, four per period.
// - Stronger filter levels suit rates up to 500 and 200 kpps.
// - Direction select swaps which command direction turns the motor CCW.
// - Ready rises once servo-on follows servo_on and forced stop both on.
// - Servo-on off stops the power stage and lets the motor coast.
// - Any alarm stops the power stage and applies the dynamic brake.
// - Forced stop off brakes dynamically and raises the forced-stop warning.
// - Position mode stroke limit off clears error, locks shaft, and drops reverse pulses too.
// - Speed mode stroke limit off stops at once and locks, allows reverse.
// - Start inputs equal: decelerate to stop in speed and positioning modes.
// - Torque mode with torque selects equal lets the motor coast.
// - Mapped limits follow auto-on selection; unmapped limits count as on.
// - Torque mode ignores both stroke limits.
// - Settings take effect only at the power cycle, not when written, except auto-on selection and limit mapping, which act at once.
// - Test forcing of each digital output and a live view of inputs.
`timescale 1ns/10ps
module servo_command_interlock #(
  parameter int LAMP_CYC  = svc_pkg::LAMP_CYC,
  parameter int LABEL_CYC = svc_pkg::LABEL_CYC,
  parameter int ENC_RES   = svc_pkg::ENC_RES_DEF
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  // Controller pins
  input  wire logic                      i_servo_on,
  input  wire logic                      i_forced_stop_input,
  input  wire logic                      i_fwd_stroke_limit,
  input  wire logic                      i_rev_stroke_limit,
  input  wire logic                      i_fwd_start_input,
  input  wire logic                      i_rev_start_input,
  input  wire logic                      i_fwd_torque_select,
  input  wire logic                      i_rev_torque_select,
  input  wire logic                      i_cmd_pulse_a,
  input  wire logic                      i_cmd_pulse_b,
  input  wire logic                      i_panel_button,
  // Settings
  input  wire logic [1:0]                i_control_mode_select,
  input  wire logic [8:0]                i_pulses_per_rev_setting,
  input  wire logic [svc_pkg::GEAR_W-1:0] i_gear_numerator,
  input  wire logic [svc_pkg::GEAR_W-1:0] i_gear_denominator,
  input  wire logic [svc_pkg::PFS_W-1:0] i_pulse_form_select,
  input  wire logic                      i_direction_select,
  input  wire logic [1:0]                i_auto_on_input_select,
  input  wire logic                      i_fwd_limit_mapped,
  input  wire logic                      i_rev_limit_mapped,
  // Internal status
  input  wire logic                      i_alarm,
  input  wire logic                      i_fb_step,
  input  wire logic                      i_fb_ccw,
  // Output test
  input  wire logic                      i_do_test_en,
  input  wire logic [svc_pkg::DO_W-1:0]  i_do_test_val,
  // Indications
  output logic                           o_ready,
  output logic                           o_alarm_out,
  output logic [7:0]                     o_warn_code,
  output logic [1:0]                     o_disp_state,
  output logic [svc_pkg::PIN_W-1:0]      o_input_view,
  // Power stage
  output logic                           o_base_on,
  output logic                           o_dyn_brake,
  output logic                           o_coast,
  output logic                           o_decel_stop,
  output logic                           o_shaft_lock,
  // Position reference
  output logic                           o_motor_step,
  output logic                           o_motor_ccw,
  output logic [svc_pkg::POS_W-1:0]      o_pos_ref,
  output logic [svc_pkg::POS_W-1:0]      o_droop
);
  if (LAMP_CYC < 1 || LABEL_CYC < 1 || ENC_RES < 1) begin : g_chk
    $error("Timing counts and encoder resolution must be positive.");
  end

  typedef struct packed {
    logic                         cfg_done;
    svc_pkg::ctrl_mode_t          mode;
    logic [1:0]                   form;
    logic                         neg;
    logic [1:0]                   filt;
    logic                         dir_sel;
    logic [31:0]                  num;
    logic [31:0]                  den;
    logic signed [33:0]           resid;
    logic [svc_pkg::POS_W-1:0]    pos;
    logic [svc_pkg::POS_W-1:0]    droop;
    logic                         ready_int;
    logic                         ready;
    logic                         alm;
    logic                         base_on;
    logic                         brake;
    logic                         coast;
    logic                         decel;
    logic                         lock;
    logic                         step;
    logic                         ccw;
    logic [7:0]                   warn;
    svc_pkg::disp_state_t         disp;
    logic [31:0]                  tmr;
    logic                         btn_prev;
    logic [svc_pkg::PIN_W-1:0]    view;
  } st_t;
  st_t st_reg;
  st_t st_next;

  logic [svc_pkg::PIN_W-1:0] pin_q;
  logic                      dec_step;
  logic                      dec_fwd;
  logic                      servo_on;
  logic                      em;
  logic                      fl_eff;
  logic                      rl_eff;
  logic                      run_ok;
  logic                      pos_like;
  logic                      lim_mode;
  logic                      accept;
  logic                      cmd_ccw;
  logic                      btn_rise;
  logic [8:0]                ppr;
  logic signed [33:0]        add;
  logic signed [33:0]        den_s;
  logic                      drain_p;
  logic                      drain_n;

  pin_sync #(
    .W (svc_pkg::PIN_W)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pin     ({i_cmd_pulse_b, i_cmd_pulse_a, i_panel_button, i_rev_torque_select,
                 i_fwd_torque_select, i_rev_start_input, i_fwd_start_input,
                 i_rev_stroke_limit, i_fwd_stroke_limit, i_forced_stop_input, i_servo_on}),
    .o_q       (pin_q)
  );

  pulse_decoder u_dec (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_a       (pin_q[svc_pkg::PIN_A]),
    .i_b       (pin_q[svc_pkg::PIN_B]),
    .i_form    (st_reg.form),
    .i_neg     (st_reg.neg),
    .i_filt    (st_reg.filt),
    .o_step    (dec_step),
    .o_fwd     (dec_fwd)
  );

  always_comb begin
    servo_on      = pin_q[svc_pkg::PIN_SON];
    em       = pin_q[svc_pkg::PIN_EM];
    // Unmapped limits read as on; torque mode never looks at them.
    fl_eff   = ~i_fwd_limit_mapped | pin_q[svc_pkg::PIN_FL] | i_auto_on_input_select[0];
    rl_eff   = ~i_rev_limit_mapped | pin_q[svc_pkg::PIN_RL] | i_auto_on_input_select[1];
    lim_mode = st_reg.mode != svc_pkg::MODE_TRQ;
    pos_like = st_reg.mode == svc_pkg::MODE_POS || st_reg.mode == svc_pkg::MODE_PTB;
    run_ok   = st_reg.cfg_done & servo_on & em & ~i_alarm;
    btn_rise = pin_q[svc_pkg::PIN_BTN] & ~st_reg.btn_prev;
    ppr      = i_pulses_per_rev_setting;
    if (ppr != svc_pkg::PPR_NATIVE && (ppr < svc_pkg::PPR_MIN || ppr > svc_pkg::PPR_MAX)) begin
      ppr = svc_pkg::PPR_DEFAULT;
    end
    cmd_ccw  = dec_fwd ^ st_reg.dir_sel;
    // Pulses outside servo-on and into a closed limit leave no reference behind.
    accept   = dec_step & st_reg.ready_int & pos_like
             & ~(lim_mode & cmd_ccw & ~fl_eff) & ~(lim_mode & ~cmd_ccw & ~rl_eff);
    add      = accept ? (cmd_ccw ? $signed({2'b00, st_reg.num}) : -$signed({2'b00, st_reg.num})) : '0;
    den_s    = $signed({2'b00, st_reg.den});
    drain_p  = st_reg.resid >= den_s;
    drain_n  = st_reg.resid <= -den_s;

    st_next          = st_reg;
    st_next.btn_prev = pin_q[svc_pkg::PIN_BTN];
    st_next.view     = pin_q;
    st_next.step     = 1'b0;

    // Settings are taken once, at the first edge after reset.
    if (!st_reg.cfg_done) begin
      st_next.cfg_done = 1'b1;
      st_next.mode     = svc_pkg::ctrl_mode_t'(i_control_mode_select);
      st_next.form     = i_pulse_form_select[svc_pkg::PFS_FORM_LSB +: 2];
      st_next.neg      = i_pulse_form_select[svc_pkg::PFS_NEG_BIT];
      st_next.filt     = i_pulse_form_select[svc_pkg::PFS_FILT_LSB +: 2];
      st_next.dir_sel  = i_direction_select;
      if (ppr == svc_pkg::PPR_NATIVE) begin
        st_next.num = (i_gear_numerator == '0) ? 32'h0000_0001 : 32'(i_gear_numerator);
        st_next.den = (i_gear_denominator == '0) ? 32'h0000_0001 : 32'(i_gear_denominator);
      end else begin
        st_next.num = 32'(ENC_RES);
        st_next.den = 32'(ppr) * svc_pkg::PPR_UNIT;
      end
    end

    // Run, coast and brake decisions.
    st_next.ready_int = run_ok;
    st_next.alm       = i_alarm;
    st_next.base_on   = run_ok & ~(st_reg.mode == svc_pkg::MODE_TRQ &&
                        pin_q[svc_pkg::PIN_FT] == pin_q[svc_pkg::PIN_RT]);
    st_next.brake     = i_alarm | ~em;
    st_next.coast     = ~st_next.base_on & ~st_next.brake;
    st_next.warn      = em ? svc_pkg::WARN_NONE : svc_pkg::WARN_ESTOP;
    st_next.decel     = run_ok & (st_reg.mode == svc_pkg::MODE_SPD || st_reg.mode == svc_pkg::MODE_PTB)
                      & (pin_q[svc_pkg::PIN_FS] == pin_q[svc_pkg::PIN_RS]);
    st_next.lock      = run_ok & lim_mode & (~fl_eff | ~rl_eff);

    // Outputs under test are forced; the block's own state keeps running.
    st_next.ready = i_do_test_en ? i_do_test_val[svc_pkg::DO_RDY] : run_ok;
    st_next.alm   = i_do_test_en ? i_do_test_val[svc_pkg::DO_ALM] : i_alarm;

    // Scaled reference: one motor step leaves the residue per clock.
    st_next.resid = st_reg.resid + add;
    if (drain_p) begin
      st_next.resid = st_next.resid - den_s;
      st_next.step  = 1'b1;
      st_next.ccw   = 1'b1;
      st_next.pos   = st_reg.pos + 32'h0000_0001;
    end else if (drain_n) begin
      st_next.resid = st_next.resid + den_s;
      st_next.step  = 1'b1;
      st_next.ccw   = 1'b0;
      st_next.pos   = st_reg.pos - 32'h0000_0001;
    end
    st_next.droop = st_reg.droop;
    if (st_next.step) begin
      st_next.droop = st_next.ccw ? st_next.droop + 32'h0000_0001 : st_next.droop - 32'h0000_0001;
    end
    if (i_fb_step) begin
      st_next.droop = i_fb_ccw ? st_next.droop - 32'h0000_0001 : st_next.droop + 32'h0000_0001;
    end
    if (st_reg.mode == svc_pkg::MODE_POS && (~fl_eff | ~rl_eff)) begin
      st_next.droop = '0;
      st_next.resid = '0;
    end

    // Start-up display; the lamp check is only a pattern, never an alarm.
    st_next.tmr = st_reg.tmr + 32'h0000_0001;
    unique case (st_reg.disp)
      svc_pkg::DSP_LAMP: begin
        if (st_reg.tmr >= 32'(LAMP_CYC - 1)) begin
          st_next.tmr  = '0;
          st_next.disp = (st_reg.mode == svc_pkg::MODE_POS) ? svc_pkg::DSP_LABEL : svc_pkg::DSP_DATA;
        end
      end
      svc_pkg::DSP_LABEL: begin
        if (btn_rise || st_reg.tmr >= 32'(LABEL_CYC - 1)) begin
          st_next.disp = svc_pkg::DSP_DATA;
        end
      end
      svc_pkg::DSP_DATA: begin
        st_next.tmr = st_reg.tmr;
      end
      default: begin
        st_next.disp = svc_pkg::DSP_DATA;
      end
    endcase
    if (!st_reg.cfg_done) begin
      st_next.tmr  = '0;
      st_next.disp = svc_pkg::DSP_LAMP;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg      <= '0;
      st_reg.mode <= svc_pkg::MODE_POS;
      st_reg.num  <= 32'h0000_0001;
      st_reg.den  <= 32'h0000_2710;
      st_reg.disp <= svc_pkg::DSP_LAMP;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_ready      = st_reg.ready;
  assign o_alarm_out  = st_reg.alm;
  assign o_warn_code  = st_reg.warn;
  assign o_disp_state = st_reg.disp;
  assign o_input_view = st_reg.view;
  assign o_base_on    = st_reg.base_on;
  assign o_dyn_brake  = st_reg.brake;
  assign o_coast      = st_reg.coast;
  assign o_decel_stop = st_reg.decel;
  assign o_shaft_lock = st_reg.lock;
  assign o_motor_step = st_reg.step;
  assign o_motor_ccw  = st_reg.ccw;
  assign o_pos_ref    = st_reg.pos;
  assign o_droop      = st_reg.droop;

  a_ready_cause: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    st_reg.ready_int |-> $past(servo_on & em & ~i_alarm))
    else $error("Ready without servo_on and forced stop.");
  a_son_coast: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!servo_on && em && !i_alarm) |=> (!o_base_on && !o_dyn_brake && o_coast))
    else $error("Servo off did not coast.");
  a_alarm_brake: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_alarm |=> (o_dyn_brake && !o_base_on))
    else $error("Alarm did not brake.");
  a_estop_warn: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !em |=> (o_dyn_brake && !o_base_on && o_warn_code == svc_pkg::WARN_ESTOP))
    else $error("Forced stop did not brake and warn.");
  a_limit_droop: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (st_reg.mode == svc_pkg::MODE_POS && !fl_eff) |=> (o_droop == '0 && st_reg.resid == '0))
    else $error("Stroke limit did not clear the error.");
  a_unready_drop: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!st_reg.ready_int && st_reg.resid == '0) |=> st_reg.resid == '0)
    else $error("Reference grew while not ready.");
  a_start_decel: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (run_ok && st_reg.mode == svc_pkg::MODE_SPD && pin_q[svc_pkg::PIN_FS] == pin_q[svc_pkg::PIN_RS])
    |=> o_decel_stop)
    else $error("Equal start inputs did not decelerate.");
  a_torque_coast: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (st_reg.mode == svc_pkg::MODE_TRQ && pin_q[svc_pkg::PIN_FT] == pin_q[svc_pkg::PIN_RT]) |=> !o_base_on)
    else $error("Equal torque selects did not coast.");
  a_torque_nolim: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    st_reg.mode == svc_pkg::MODE_TRQ |=> !o_shaft_lock)
    else $error("Torque mode honoured a stroke limit.");
  a_cfg_frozen: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    st_reg.cfg_done |=> ($stable(st_reg.mode) && $stable(st_reg.num) && $stable(st_reg.dir_sel)))
    else $error("Settings changed without a power cycle.");
  a_label_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_disp_state == svc_pkg::DSP_LABEL && !btn_rise && st_reg.tmr < 32'(LABEL_CYC - 1))
    |=> o_disp_state == svc_pkg::DSP_LABEL)
    else $error("Label left early.");
  a_lamp_quiet: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_disp_state == svc_pkg::DSP_LAMP && $past(em)) |-> o_warn_code == svc_pkg::WARN_NONE)
    else $error("Lamp check raised a warning.");

  c_ready: cover property (@(posedge i_sys_clk) disable iff (i_rst) $rose(o_ready));
  c_step: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_motor_step);
  c_lock: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_shaft_lock);
  c_data: cover property (@(posedge i_sys_clk) disable iff (i_rst) $rose(o_disp_state == svc_pkg::DSP_DATA));
endmodule

// File: tb/ctl_model.sv
/*
  Positioning controller model that sends command pulse trains.
  Assumes the bench starts bursts only after reset is released.
*/
`timescale 1ns/10ps
module ctl_model (
  // Clock
  input  wire logic i_sys_clk,
  // Pulse pins
  output logic      o_a,
  output logic      o_b
);
  initial begin
    o_a = 1'b0;
    o_b = 1'b0;
  end
  task automatic burst(input int n, input bit quad);
    for (int i = 0; i < n; i++) begin
      for (int e = 0; e < 4; e++) begin
        @(negedge i_sys_clk);
        // A leads B, so one phase changes per edge; edges outlast the first filter level.
        if (quad && e[0]) o_b <= ~o_b;
        else if (quad || e == 0) o_a <= ~o_a;
        else if (e == 1) o_a <= 1'b0;
        repeat (60) @(negedge i_sys_clk);
      end
    end
  endtask
endmodule

// File: tb/servo_command_interlock_tb.sv
/*
  Self-checking bench of the servo command and interlock block.
  Assumes ctl_model as the controller and shortened display counts.
*/
`timescale 1ns/10ps
module servo_command_interlock_tb;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_servo_on = 1'b0, i_forced_stop_input = 1'b0, i_alarm = 1'b0;
  logic i_fwd_stroke_limit = 1'b1, i_rev_stroke_limit = 1'b1, i_fwd_limit_mapped = 1'b1, i_rev_limit_mapped = 1'b1;
  logic i_fwd_start_input = 1'b0, i_rev_start_input = 1'b0, i_fwd_torque_select = 1'b0, i_rev_torque_select = 1'b0;
  logic i_panel_button = 1'b0, i_direction_select = 1'b0, i_fb_step = 1'b0, i_fb_ccw = 1'b0, i_do_test_en = 1'b0;
  logic [1:0] i_control_mode_select = 2'h0, i_auto_on_input_select = 2'h0, i_do_test_val = 2'h0, o_disp_state;
  logic [8:0] i_pulses_per_rev_setting = 9'h064;
  logic [15:0] i_gear_numerator = 16'h0001, i_gear_denominator = 16'h0001;
  logic [5:0] i_pulse_form_select = 6'h00;
  logic i_cmd_pulse_a, i_cmd_pulse_b, o_ready, o_alarm_out, o_base_on, o_dyn_brake, o_coast, o_decel_stop;
  logic o_shaft_lock, o_motor_step, o_motor_ccw;
  logic [7:0] o_warn_code;
  logic [10:0] o_input_view;
  logic [31:0] o_pos_ref, o_droop, exp_q[$], lfsr = 32'h8b77;
  int sel_q[$], bad_count = 0, cmp_count = 0, n, k, p, steps = 0;
  event probe;
  wire [7:0] flags = {o_decel_stop, o_input_view[0], o_shaft_lock, o_coast, o_dyn_brake, o_base_on,
                      o_alarm_out, o_ready};
  servo_command_interlock #(.LAMP_CYC(20), .LABEL_CYC(50)) dut (.*);
  ctl_model ctl (.i_sys_clk(i_sys_clk), .o_a(i_cmd_pulse_a), .o_b(i_cmd_pulse_b));
  always #2 i_sys_clk = ~i_sys_clk;
  always @(negedge i_sys_clk) begin
    if (o_motor_step === 1'b1) begin
      steps++;
    end
  end
  task automatic note(input int s, input logic [31:0] v);
    sel_q.push_back(s);
    exp_q.push_back(v);
    -> probe;
  endtask
  task automatic settle(input int c);
    repeat (c) @(negedge i_sys_clk);
  endtask
  task automatic compare(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // The monitor drains every note, so two notes in one step are never lost.
  always @(probe) begin
    while (sel_q.size() > 0) begin
      k = sel_q.pop_front();
      compare(exp_q.pop_front(), k < 8 ? 32'(flags[k]) : k == 8 ? 32'(o_warn_code) : k == 9 ? 32'(o_disp_state)
        : k == 10 ? o_pos_ref : k == 11 ? o_droop : k == 12 ? 32'(o_motor_ccw) : 32'(steps));
    end
  end
  task automatic summarize();
    #1;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #40000;
    bad_count++;
    summarize();
  end
  initial begin
    settle(3);
    i_rst = 1'b0;
    settle(2);
    note(9, 32'h0);
    note(1, 32'h0);
    settle(10);
    note(8, 32'h61);
    note(3, 32'h1);
    ctl.burst(3, 1'b0);
    settle(30);
    note(10, 32'h0);
    i_forced_stop_input = 1'b1;
    i_servo_on = 1'b1;
    settle(10);
    note(0, 32'h1);
    note(2, 32'h1);
    note(6, 32'h1);
    note(8, 32'h0);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    n = 32'(lfsr[2:0]) + 1;
    {i_fwd_start_input, i_rev_start_input, i_fwd_torque_select, i_rev_torque_select} = lfsr[6:3];
    ctl.burst(n, 1'b0);
    settle(30);
    p = n * svc_pkg::ENC_RES_DEF / 10000;
    note(10, p);
    note(11, p);
    i_fwd_stroke_limit = 1'b0;
    ctl.burst(2, 1'b0);
    settle(30);
    note(11, 32'h0);
    note(5, 32'h1);
    note(10, p);
    i_fwd_stroke_limit = 1'b1;
    i_servo_on = 1'b0;
    settle(10);
    note(4, 32'h1);
    note(3, 32'h0);
    i_servo_on = 1'b1;
    i_alarm = 1'b1;
    settle(10);
    note(3, 32'h1);
    note(2, 32'h0);
    i_alarm = 1'b0;
    i_do_test_en = 1'b1;
    i_do_test_val = 2'h2;
    settle(4);
    note(0, 32'h0);
    note(1, 32'h1);
    note(9, 32'h2);
    i_do_test_en = 1'b0;
    i_rst = 1'b1;
    // Negative logic with the first filter level; the filter must settle before pulses start.
    i_pulse_form_select = 6'h16;
    i_pulses_per_rev_setting = 9'h1f4;
    i_direction_select = 1'b1;
    settle(3);
    i_rst = 1'b0;
    settle(60);
    ctl.burst(2, 1'b1);
    settle(30);
    note(10, -(8 * svc_pkg::ENC_RES_DEF / 50000));
    note(12, 32'h0);
    note(13, p + 8 * svc_pkg::ENC_RES_DEF / 50000);
    for (int m = 1; m < 3; m++) begin
      i_rst = 1'b1;
      i_control_mode_select = 2'(m);
      {i_fwd_start_input, i_rev_start_input, i_fwd_torque_select, i_rev_torque_select, i_fwd_stroke_limit} = 5'h18;
      settle(3);
      i_rst = 1'b0;
      settle(10);
      note(7, 32'(m == 1));
      note(5, 32'(m == 1));
      note(2, 32'(m == 1));
    end
    summarize();
  end
endmodule
